// ==== nibble_datapath_pkg.sv ====
// Shared constants, opcode fields and types for the nibble accumulator datapath
`default_nettype none
package nibble_datapath_pkg;

	// Widths and sizes
	localparam int NIB_W = 4;
	localparam int WORD_W = 10;
	localparam int REG_CNT = 32;
	localparam int REG_IDX_W = 5;
	localparam int PAGE_W = 3;
	localparam int PTR_W = 8;
	localparam int ROM_ADDR_W = PAGE_W + PTR_W;
	localparam int PORT_SLOTS = 8;
	localparam int PORT_SLOT_W = 3;
	localparam int PORT_BUS_W = PORT_SLOTS * NIB_W;
	localparam int SYNC_STAGES = 3;

	// Values after reset
	localparam logic [3:0] ACC_RST = 4'h0;
	localparam logic CARRY_RST = 1'b0;
	localparam logic [3:0] NIB_RST = 4'h0;
	localparam logic [2:0] PAGE_RST = 3'h0;

	// Opcode group in bits 9..6
	localparam logic [3:0] GRP_AND = 4'hD;
	localparam logic [3:0] GRP_OR = 4'hE;
	localparam logic [3:0] GRP_XOR = 4'hA;
	localparam logic [3:0] GRP_MOV = 4'hF;
	localparam logic [3:0] GRP_OUT = 4'h2;

	// Field positions inside the first word
	localparam int BIT_BANK = 5;
	localparam int BIT_KIND = 4;
	localparam int BIT_PORT = 3;

	// Low-nibble tags for the non-register forms
	localparam logic [3:0] LOW_ROM = 4'h0;
	localparam logic [3:0] LOW_IMM = 4'h1;

	// Whole-word opcodes, and the bits 9..3 prefix of the immediate output form
	localparam logic [9:0] OPC_INC = 10'h293;
	localparam logic [9:0] OPC_RL = 10'h3D3;
	localparam logic [9:0] OPC_RLZ = 10'h3F3;
	localparam logic [6:0] OPC_OUT_IMM_HI = 7'h12;

	// Pointer pair R10 (high) : R00 (low)
	localparam logic [4:0] PTR_LOW_IDX = 5'h00;
	localparam logic [4:0] PTR_HIGH_IDX = 5'h10;

	typedef enum {
		OP_NONE, OP_AND, OP_OR, OP_XOR, OP_LOAD, OP_INC, OP_RL, OP_RLZ, OP_OUT, OP_OUT_IMM
	} op_t;

	typedef enum {SRC_REG, SRC_ROM, SRC_PORT, SRC_IMM} src_t;

	// Port code 0,1,3,4 to slot 0..3 within a bank; bit 3 of result flags a bad code
	function automatic logic [3:0] port_slot(input logic bank, input logic [2:0] code);
		logic [3:0] r;
		r = 4'h8;
		case (code)
			3'h0: r = {1'b0, bank, 2'h0};
			3'h1: r = {1'b0, bank, 2'h1};
			3'h3: r = {1'b0, bank, 2'h2};
			3'h4: r = {1'b0, bank, 2'h3};
			default: r = 4'h8;
		endcase
		return r;
	endfunction

endpackage
`default_nettype wire

// ==== nibble_register_file.sv ====
// Thirty-two nibble general registers with one write port, one indexed read port and the pointer pair read out
`default_nettype none
module nibble_register_file (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clkEn,
	// Write port
	input wire logic wrEn,
	input wire logic [4:0] wrIdx,
	input wire logic [3:0] wrData,
	// Read ports
	input wire logic [4:0] rdIdx,
	output logic [3:0] rdData,
	output logic [3:0] ptrLow,
	output logic [3:0] ptrHigh
);

	logic [3:0] regs_q [nibble_datapath_pkg::REG_CNT];

	genvar i;
	generate
		for (i = 0; i < nibble_datapath_pkg::REG_CNT; i++) begin : g_entry
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					regs_q[i] <= nibble_datapath_pkg::NIB_RST;
				end else if (clkEn && wrEn && wrIdx == 5'(i)) begin
					regs_q[i] <= wrData;
				end
			end
		end
	endgenerate

	assign rdData = regs_q[rdIdx];
	assign ptrLow = regs_q[nibble_datapath_pkg::PTR_LOW_IDX];
	assign ptrHigh = regs_q[nibble_datapath_pkg::PTR_HIGH_IDX];

endmodule
`default_nettype wire

// ==== port_pin_synchronizer.sv ====
// Three-stage pin synchroniser that accepts a bit once stages two and three agree
`default_nettype none
module port_pin_synchronizer #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clkEn,
	// Pins and settled value
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] settled
);

	genvar b;
	generate
		for (b = 0; b < WIDTH; b++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic val_q;
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
				end else if (clkEn) begin
					s1_q <= pinIn[b];
					s2_q <= s1_q;
					s3_q <= s2_q;
				end
			end
			// Only the later stages are compared; stage one may be metastable
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					val_q <= 1'b0;
				end else if (clkEn && s2_q == s3_q) begin
					val_q <= s3_q;
				end
			end
			assign settled[b] = val_q;
		end
	endgenerate

endmodule
`default_nettype wire

// ==== nibble_accumulator_io_datapath.sv ====
// Accumulator, logic, rotate, port and load datapath of the 4-bit controller
`default_nettype none
// Behaviour
// - AND with ROM upper or lower nibble
// - ROM AND carry is A3 and ROM7/ROM3
// - AND immediate nibble into accumulator
// - OR register into accumulator, carry cleared
// - OR ROM nibble into accumulator, carry cleared
// - OR immediate into accumulator, carry cleared
// - XOR register; carry is A3 and reg3
// - XOR ROM nibble; carry A3 and ROM7/ROM3
// - XOR second-word immediate; carry A3 and imm3
// - Increment accumulator; carry when result wraps zero
// - Rotate left, bit3 to bit0, carry old bit3
// - Rotate-or-reset clears A, carry and port latches when accumulator zero
// - Port input loads accumulator, carry cleared
// - Port output latches accumulator until rewritten or internally reset
// - AND port; carry A3 and port bit3
// - OR port nibble into accumulator
// - XOR port; carry A3 and port bit3
// - Immediate byte written to port pair
// - Register load into accumulator, carry cleared
// - ROM upper/lower nibble load, carry cleared
// - Immediate nibble load, carry cleared
// - ROM address is page plus pointer pair
// - AND register; carry A3 and reg3
module nibble_accumulator_io_datapath (
	// Clock, enable and reset
	input wire logic clk,
	input wire logic clkEn,
	input wire logic arst_n,
	// Instruction issue
	input wire logic execStb,
	input wire logic [9:0] opWord,
	input wire logic [9:0] argWord,
	// Program memory
	output logic [10:0] romAddr,
	input wire logic [9:0] romData,
	// Page select control register load
	input wire logic pageWrEn,
	input wire logic [2:0] pageWrData,
	// General register load
	input wire logic regWrEn,
	input wire logic [4:0] regWrIdx,
	input wire logic [3:0] regWrData,
	// Port pins
	input wire logic [31:0] portPinIn,
	output logic [31:0] portOut,
	// Core state
	output logic [3:0] accumulator,
	output logic carryFlag,
	output logic internalReset,
	output logic execDone,
	output logic badPort
);

	// Decoded instruction
	nibble_datapath_pkg::op_t op;
	nibble_datapath_pkg::src_t src;
	logic [3:0] grp;
	logic bankSel;
	logic romUpper;
	logic [4:0] regIdx;
	logic [3:0] slotInfo;
	logic slotBad;
	logic [2:0] slot;

	// Operands and results
	logic [3:0] regVal;
	logic [3:0] ptrLow;
	logic [3:0] ptrHigh;
	logic [31:0] portIn;
	logic [3:0] portVal;
	logic [3:0] romNib;
	logic [3:0] immNib;
	logic [3:0] operand;
	logic [3:0] acc_d;
	logic carry_d;
	logic accWr;
	logic rlzTrip;
	logic accLoad;
	logic outWr;
	logic outImmWr;
	logic portForm;

	// Registered state
	logic [3:0] acc_q;
	logic carry_q;
	logic [2:0] page_q;
	logic [2:0] page_d;
	logic [3:0] ptrLow_d;
	logic [3:0] ptrHigh_d;
	logic [10:0] romAddr_q;
	logic [10:0] romAddr_d;
	logic [3:0] portLatch_q [nibble_datapath_pkg::PORT_SLOTS];
	logic intReset_q;
	logic done_q;
	logic badPort_q;
	logic fire;

	// Nothing moves on an edge with the enable low
	assign fire = clkEn && execStb;

	// General registers; the pointer pair is read straight from it
	nibble_register_file u_regs (
		.clk(clk),
		.arst_n(arst_n),
		.clkEn(clkEn),
		.wrEn(regWrEn),
		.wrIdx(regWrIdx),
		.wrData(regWrData),
		.rdIdx(regIdx),
		.rdData(regVal),
		.ptrLow(ptrLow),
		.ptrHigh(ptrHigh)
	);

	// Port pins arrive from outside the clock domain
	// Pins take four enabled edges to reach an operand
	port_pin_synchronizer #(
		.WIDTH(nibble_datapath_pkg::PORT_BUS_W)
	) u_pinSync (
		.clk(clk),
		.arst_n(arst_n),
		.clkEn(clkEn),
		.pinIn(portPinIn),
		.settled(portIn)
	);

	// Field extraction
	assign grp = opWord[9:6];
	assign bankSel = opWord[nibble_datapath_pkg::BIT_BANK];
	assign romUpper = ~opWord[nibble_datapath_pkg::BIT_BANK];
	assign regIdx = {opWord[nibble_datapath_pkg::BIT_BANK], opWord[3:0]};
	assign slotInfo = nibble_datapath_pkg::port_slot(bankSel, opWord[2:0]);
	assign slotBad = slotInfo[3];
	assign slot = slotInfo[2:0];
	assign immNib = argWord[3:0];

	// Decoder for the accumulator, port and load groups
	always_comb begin
		op = nibble_datapath_pkg::OP_NONE;
		src = nibble_datapath_pkg::SRC_REG;
		// Whole-word forms first; they overlap the group encodings
		if (opWord == nibble_datapath_pkg::OPC_INC) begin
			op = nibble_datapath_pkg::OP_INC;
		end else if (opWord == nibble_datapath_pkg::OPC_RL) begin
			op = nibble_datapath_pkg::OP_RL;
		end else if (opWord == nibble_datapath_pkg::OPC_RLZ) begin
			op = nibble_datapath_pkg::OP_RLZ;
		end else if (opWord[9:3] == nibble_datapath_pkg::OPC_OUT_IMM_HI) begin
			op = nibble_datapath_pkg::OP_OUT_IMM;
			src = nibble_datapath_pkg::SRC_IMM;
		end else if (grp == nibble_datapath_pkg::GRP_OUT) begin
			if (opWord[nibble_datapath_pkg::BIT_KIND] && opWord[nibble_datapath_pkg::BIT_PORT]) begin
				op = nibble_datapath_pkg::OP_OUT;
				src = nibble_datapath_pkg::SRC_PORT;
			end
		end else begin
			case (grp)
				nibble_datapath_pkg::GRP_AND: op = nibble_datapath_pkg::OP_AND;
				nibble_datapath_pkg::GRP_OR: op = nibble_datapath_pkg::OP_OR;
				nibble_datapath_pkg::GRP_XOR: op = nibble_datapath_pkg::OP_XOR;
				nibble_datapath_pkg::GRP_MOV: op = nibble_datapath_pkg::OP_LOAD;
				default: op = nibble_datapath_pkg::OP_NONE;
			endcase
			if (!opWord[nibble_datapath_pkg::BIT_KIND]) begin
				src = nibble_datapath_pkg::SRC_REG;
			end else if (opWord[nibble_datapath_pkg::BIT_PORT]) begin
				src = nibble_datapath_pkg::SRC_PORT;
			end else if (opWord[3:0] == nibble_datapath_pkg::LOW_ROM) begin
				src = nibble_datapath_pkg::SRC_ROM;
			end else if (opWord[3:0] == nibble_datapath_pkg::LOW_IMM && bankSel) begin
				src = nibble_datapath_pkg::SRC_IMM;
			end else begin
				op = nibble_datapath_pkg::OP_NONE;
			end
		end
	end

	// Upper form takes bits 7-4, lower form bits 3-0; bits 9 and 8 never reach A
	assign romNib = romUpper ? romData[7:4] : romData[3:0];

	// Port read: the settled pin value of the selected slot, bit 3 weighs for carry
	assign portVal = slotBad ? 4'h0 : portIn[{slot, 2'h0} +: 4];

	// Operand mux; a bad port code feeds zero to the ALU
	always_comb begin
		case (src)
			nibble_datapath_pkg::SRC_REG: operand = regVal;
			nibble_datapath_pkg::SRC_ROM: operand = romNib;
			nibble_datapath_pkg::SRC_PORT: operand = portVal;
			nibble_datapath_pkg::SRC_IMM: operand = immNib;
			default: operand = 4'h0;
		endcase
	end

	assign rlzTrip = (op == nibble_datapath_pkg::OP_RLZ) && (acc_q == 4'h0);

	// A zero rotate-or-reset leaves A and carry for the clear that follows
	assign accLoad = fire && accWr && !rlzTrip;
	// A bad port code writes no latch
	assign outWr = fire && !slotBad && op == nibble_datapath_pkg::OP_OUT;
	assign outImmWr = fire && !slotBad && op == nibble_datapath_pkg::OP_OUT_IMM;
	// Undecoded words never flag a port code, even in port form
	assign portForm = op != nibble_datapath_pkg::OP_NONE
		&& (src == nibble_datapath_pkg::SRC_PORT || op == nibble_datapath_pkg::OP_OUT_IMM);

	// Result and carry; the carry terms all use the accumulator before the update
	always_comb begin
		acc_d = acc_q;
		carry_d = carry_q;
		accWr = 1'b0;
		case (op)
			nibble_datapath_pkg::OP_AND: begin
				acc_d = acc_q & operand;
				carry_d = acc_q[3] & operand[3];
				accWr = 1'b1;
			end
			nibble_datapath_pkg::OP_OR: begin
				acc_d = acc_q | operand;
				carry_d = 1'b0;
				accWr = 1'b1;
			end
			nibble_datapath_pkg::OP_XOR: begin
				acc_d = acc_q ^ operand;
				carry_d = acc_q[3] & operand[3];
				accWr = 1'b1;
			end
			nibble_datapath_pkg::OP_LOAD: begin
				acc_d = operand;
				carry_d = 1'b0;
				accWr = 1'b1;
			end
			nibble_datapath_pkg::OP_INC: begin
				acc_d = 4'(acc_q + 4'h1);
				carry_d = (acc_q == 4'hF);
				accWr = 1'b1;
			end
			nibble_datapath_pkg::OP_RL, nibble_datapath_pkg::OP_RLZ: begin
				acc_d = {acc_q[2:0], acc_q[3]};
				carry_d = acc_q[3];
				accWr = 1'b1;
			end
			default: begin
				acc_d = acc_q;
				carry_d = carry_q;
				accWr = 1'b0;
			end
		endcase
	end

	// Accumulator and carry; a zero rotate-or-reset wins over the rotate
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_q <= nibble_datapath_pkg::ACC_RST;
			carry_q <= nibble_datapath_pkg::CARRY_RST;
		end else if (clkEn && intReset_q) begin
			acc_q <= nibble_datapath_pkg::ACC_RST;
			carry_q <= nibble_datapath_pkg::CARRY_RST;
		end else if (accLoad) begin
			acc_q <= acc_d;
			carry_q <= carry_d;
		end
	end

	// Internal reset: one pulse, then the next cycle clears the core state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			intReset_q <= 1'b0;
		end else if (clkEn) begin
			intReset_q <= fire && rlzTrip;
		end
	end

	// Port output latches hold until rewritten or internally reset
	genvar p;
	generate
		for (p = 0; p < nibble_datapath_pkg::PORT_SLOTS; p++) begin : g_port
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					portLatch_q[p] <= nibble_datapath_pkg::NIB_RST;
				end else if (clkEn && intReset_q) begin
					portLatch_q[p] <= nibble_datapath_pkg::NIB_RST;
				end else if (outWr && slot == 3'(p)) begin
					portLatch_q[p] <= acc_q;
				end else if (outImmWr && slot[1:0] == 2'(p % 4)) begin
					// High bank takes the upper nibble of the byte
					portLatch_q[p] <= (p >= 4) ? argWord[7:4] : argWord[3:0];
				end
			end
			assign portOut[p*4 +: 4] = portLatch_q[p];
		end
	endgenerate

	// Page select control register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			page_q <= nibble_datapath_pkg::PAGE_RST;
		end else if (clkEn && pageWrEn) begin
			page_q <= pageWrData;
		end
	end

	// Address follows the next page and pointer values so the output stays registered
	assign page_d = pageWrEn ? pageWrData : page_q;
	assign ptrLow_d = (regWrEn && regWrIdx == nibble_datapath_pkg::PTR_LOW_IDX)
		? regWrData : ptrLow;
	assign ptrHigh_d = (regWrEn && regWrIdx == nibble_datapath_pkg::PTR_HIGH_IDX)
		? regWrData : ptrHigh;
	assign romAddr_d = {page_d, ptrHigh_d, ptrLow_d};

	// Reset address is built from the reset values of its parts
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			romAddr_q <= {nibble_datapath_pkg::PAGE_RST, nibble_datapath_pkg::NIB_RST,
				nibble_datapath_pkg::NIB_RST};
		end else if (clkEn) begin
			romAddr_q <= romAddr_d;
		end
	end

	// Completion and bad port index flags, one cycle each
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			done_q <= 1'b0;
			badPort_q <= 1'b0;
		end else if (clkEn) begin
			done_q <= fire && op != nibble_datapath_pkg::OP_NONE;
			badPort_q <= fire && slotBad && portForm;
		end
	end

	assign accumulator = acc_q;
	assign carryFlag = carry_q;
	assign romAddr = romAddr_q;
	assign internalReset = intReset_q;
	assign execDone = done_q;
	assign badPort = badPort_q;

endmodule
`default_nettype wire

// ==== nibble_datapath_chk.sv ====
// Port-level assertions for the nibble accumulator datapath
`default_nettype none
module nibble_datapath_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic clkEn,
	input wire logic arst_n,
	// Issue and loads
	input wire logic execStb,
	input wire logic [9:0] opWord,
	input wire logic [9:0] argWord,
	input wire logic pageWrEn,
	input wire logic [2:0] pageWrData,
	input wire logic regWrEn,
	// Results
	input wire logic [10:0] romAddr,
	input wire logic [31:0] portOut,
	input wire logic [3:0] accumulator,
	input wire logic carryFlag,
	input wire logic internalReset,
	input wire logic execDone
);
	timeunit 1ns;
	timeprecision 1ns;
	logic req;
	logic take;
	logic [3:0] immQ;
	assign req = clkEn && execStb;
	// Internal reset cycle discards the accumulator effect
	assign take = req && !internalReset;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			immQ <= 4'h0;
		end else begin
			immQ <= argWord[3:0];
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	property p_done;
		execDone |-> $past(req);
	endproperty
	a_done: assert property (p_done) else $error("done without request");
	property p_inc;
		take && opWord == nibble_datapath_pkg::OPC_INC
		|=> accumulator == $past(accumulator) + 4'h1 && carryFlag == (accumulator == 4'h0);
	endproperty
	a_inc: assert property (p_inc) else $error("increment wrong");
	property p_rot;
		take && (opWord == nibble_datapath_pkg::OPC_RL
			|| opWord == nibble_datapath_pkg::OPC_RLZ && accumulator != 4'h0)
		|=> $past(accumulator) == {accumulator[0], accumulator[3:1]} && carryFlag == accumulator[0];
	endproperty
	a_rot: assert property (p_rot) else $error("rotate wrong");
	property p_rlz_zero;
		take && opWord == nibble_datapath_pkg::OPC_RLZ && accumulator == 4'h0 |-> ##[1:2] internalReset;
	endproperty
	a_rlz_zero: assert property (p_rlz_zero) else $error("no internal reset");
	property p_clear;
		internalReset && clkEn |=> accumulator == 4'h0 && !carryFlag && portOut == 32'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("state kept over internal reset");
	property p_ldi;
		take && opWord == 10'h3F1 |=> accumulator == immQ && !carryFlag;
	endproperty
	a_ldi: assert property (p_ldi) else $error("load immediate wrong");
	property p_andi;
		take && opWord == 10'h371 |=> accumulator == ($past(accumulator) & immQ);
	endproperty
	a_andi: assert property (p_andi) else $error("and immediate wrong");
	property p_ori;
		take && opWord == 10'h3B1 |=> accumulator == ($past(accumulator) | immQ) && !carryFlag;
	endproperty
	a_ori: assert property (p_ori) else $error("or immediate wrong");
	property p_xori;
		take && opWord == 10'h2B1
		|=> accumulator == ($past(accumulator) ^ immQ) && carryFlag == (immQ[3] && !accumulator[3]);
	endproperty
	a_xori: assert property (p_xori) else $error("xor immediate wrong");
	property p_page;
		pageWrEn && clkEn ##1 !pageWrEn |-> ##1 romAddr[10:8] == $past(pageWrData, 2);
	endproperty
	a_page: assert property (p_page) else $error("page bits not in address");
	property p_addr_hold;
		(clkEn && !pageWrEn && !regWrEn) [*2] |=> $stable(romAddr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved");
	cover property (take && opWord == nibble_datapath_pkg::OPC_RLZ && accumulator == 4'h0);
	cover property (execDone ##1 execDone);
	cover property (take && opWord == nibble_datapath_pkg::OPC_INC && accumulator == 4'hF);
endmodule
bind nibble_accumulator_io_datapath nibble_datapath_chk nibble_datapath_chk_i (
	.clk(clk), .clkEn(clkEn), .arst_n(arst_n), .execStb(execStb), .opWord(opWord),
	.argWord(argWord), .pageWrEn(pageWrEn), .pageWrData(pageWrData), .regWrEn(regWrEn),
	.romAddr(romAddr), .portOut(portOut), .accumulator(accumulator), .carryFlag(carryFlag),
	.internalReset(internalReset), .execDone(execDone)
);
`default_nettype wire

// ==== rom_pin_model.sv ====
// Program memory and port pin model facing the datapath
`default_nettype none
module rom_pin_model (
	// Program memory
	input wire logic [10:0] romAddr,
	output logic [9:0] romData,
	// Pin levels
	input wire logic [31:0] pinLevel,
	output logic [31:0] pins
);
	timeunit 1ns;
	timeprecision 1ns;
	// Page bits mixed into bits 9-5 so a wrong page shows in the upper nibble
	assign romData = {romAddr[10:9], romAddr[7:0] ^ {romAddr[10:8], 5'h1A}};
	assign pins = pinLevel;
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the nibble accumulator datapath
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [9:0] op; logic [3:0] arg, accIn, acc; logic cy, chkCy;} row_t;
	logic clk = 1'b0;
	logic clkEn = 1'b1;
	logic arst_n = 1'b0;
	logic execStb = 1'b0;
	logic [9:0] opWord = 10'h000, argWord = 10'h000, romData;
	logic [10:0] romAddr;
	logic pageWrEn = 1'b0, regWrEn = 1'b0;
	logic [2:0] pageWrData = 3'h0;
	logic [4:0] regWrIdx = 5'h00;
	logic [3:0] regWrData = 4'h0, accumulator;
	logic [31:0] portPinIn, portOut, pinLevel = 32'h8765_4321;
	logic carryFlag, internalReset, execDone, badPort;
	int errCount = 0, checkCount = 0, cycles = 0, n;
	// Operand setup: ROM word D9, reg 05 = C, reg 15 = 9, pins per slot 1..8
	row_t rows[22] = '{
		'{10'h350, 4'h0, 4'hF, 4'hD, 1'b1, 1'b1}, '{10'h370, 4'h0, 4'h7, 4'h1, 1'b0, 1'b1},
		'{10'h371, 4'h6, 4'hF, 4'h6, 1'b0, 1'b0}, '{10'h365, 4'h0, 4'hC, 4'h8, 1'b1, 1'b1},
		'{10'h385, 4'h0, 4'h1, 4'hD, 1'b0, 1'b1}, '{10'h390, 4'h0, 4'h2, 4'hF, 1'b0, 1'b1},
		'{10'h3B1, 4'h4, 4'h1, 4'h5, 1'b0, 1'b1}, '{10'h2A5, 4'h0, 4'h8, 4'h1, 1'b1, 1'b1},
		'{10'h290, 4'h0, 4'hC, 4'h1, 1'b1, 1'b1}, '{10'h2B0, 4'h0, 4'h1, 4'h8, 1'b0, 1'b1},
		'{10'h2B1, 4'h9, 4'h8, 4'h1, 1'b1, 1'b1}, '{10'h293, 4'h0, 4'hF, 4'h0, 1'b1, 1'b1},
		'{10'h293, 4'h0, 4'h7, 4'h8, 1'b0, 1'b1}, '{10'h3D3, 4'h0, 4'h9, 4'h3, 1'b1, 1'b1},
		'{10'h3F3, 4'h0, 4'h6, 4'hC, 1'b0, 1'b1}, '{10'h3FB, 4'h0, 4'h5, 4'h7, 1'b0, 1'b1},
		'{10'h37C, 4'h0, 4'hF, 4'h8, 1'b1, 1'b1}, '{10'h398, 4'h0, 4'h8, 4'h9, 1'b0, 1'b1},
		'{10'h2BC, 4'h0, 4'hC, 4'h4, 1'b1, 1'b1}, '{10'h3E5, 4'h0, 4'h3, 4'h9, 1'b0, 1'b1},
		'{10'h3D0, 4'h0, 4'h1, 4'hD, 1'b0, 1'b1}, '{10'h3F0, 4'h0, 4'h1, 4'h9, 1'b0, 1'b1}
	};
	nibble_accumulator_io_datapath nibble_accumulator_io_datapath_i (
		.clk(clk), .clkEn(clkEn), .arst_n(arst_n), .execStb(execStb), .opWord(opWord),
		.argWord(argWord), .romAddr(romAddr), .romData(romData), .pageWrEn(pageWrEn),
		.pageWrData(pageWrData), .regWrEn(regWrEn), .regWrIdx(regWrIdx), .regWrData(regWrData),
		.portPinIn(portPinIn), .portOut(portOut), .accumulator(accumulator), .carryFlag(carryFlag),
		.internalReset(internalReset), .execDone(execDone), .badPort(badPort)
	);
	rom_pin_model rom_pin_model_i (
		.romAddr(romAddr), .romData(romData), .pinLevel(pinLevel), .pins(portPinIn)
	);
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errCount++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic exec(input logic [9:0] op, input logic [9:0] arg);
		@(posedge clk);
		execStb <= 1'b1;
		opWord <= op;
		argWord <= arg;
		@(posedge clk);
		execStb <= 1'b0;
		#1;
	endtask
	task automatic wrReg(input logic [4:0] idx, input logic [3:0] val);
		@(posedge clk);
		regWrEn <= 1'b1;
		regWrIdx <= idx;
		regWrData <= val;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errCount++;
			results();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		check({accumulator, carryFlag, portOut, romAddr}, 48'h0);
		arst_n <= 1'b1;
		$display("reset test done");
		wrReg(5'h00, 4'h3);
		wrReg(5'h10, 4'h6);
		wrReg(5'h05, 4'hC);
		wrReg(5'h15, 4'h9);
		@(posedge clk);
		pageWrEn <= 1'b1;
		pageWrData <= 3'h5;
		@(posedge clk);
		pageWrEn <= 1'b0;
		repeat (4) @(posedge clk);
		check(romAddr, 11'h563);
		foreach (rows[i]) begin
			exec(10'h3F1, {6'h00, rows[i].accIn});
			check({accumulator, carryFlag}, {rows[i].accIn, 1'b0});
			exec(rows[i].op, {6'h00, rows[i].arg});
			check({accumulator, execDone}, {rows[i].acc, 1'b1});
			if (rows[i].chkCy) check(carryFlag, rows[i].cy);
			$display("row %0d done", i);
		end
		exec(10'h3F1, 10'h005);
		exec(10'h0BB, 10'h000);
		exec(10'h3F1, 10'h002);
		check(portOut[27:24], 4'h5);
		exec(10'h091, 10'h0C7);
		check({portOut[23:20], portOut[7:4]}, 8'hC7);
		$display("port output test done");
		// Port code 2 does not exist
		exec(10'h3DA, 10'h000);
		check({badPort, accumulator, carryFlag}, 6'h20);
		$display("bad port test done");
		// A pin change is not seen before the synchroniser settles
		@(posedge clk);
		pinLevel[3:0] <= 4'hA;
		exec(10'h3D8, 10'h000);
		check({accumulator, carryFlag}, 5'h02);
		repeat (2) @(posedge clk);
		exec(10'h3D8, 10'h000);
		check({accumulator, carryFlag}, 5'h14);
		$display("pin settle test done");
		@(posedge clk);
		execStb <= 1'b1;
		opWord <= 10'h3F1;
		argWord <= 10'h00F;
		@(posedge clk);
		opWord <= 10'h293;
		@(posedge clk);
		execStb <= 1'b0;
		#1;
		check({accumulator, carryFlag, execDone}, 6'h03);
		$display("back-to-back test done");
		// Enable low: a request is ignored and all state holds
		@(posedge clk);
		clkEn <= 1'b0;
		exec(10'h293, 10'h000);
		check({accumulator, carryFlag, execDone}, 6'h02);
		@(posedge clk);
		clkEn <= 1'b1;
		$display("clock enable test done");
		// Carry set beforehand so the later clear is visible
		exec(10'h3F1, 10'h00F);
		exec(10'h293, 10'h000);
		exec(10'h3F3, 10'h000);
		check({accumulator, carryFlag}, 5'h01);
		n = 0;
		while (internalReset !== 1'b1 && n < 3) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(internalReset, 1'b1);
		@(posedge clk);
		#1;
		check({portOut, accumulator, carryFlag}, 37'h0);
		$display("internal reset test done");
		results();
	end
endmodule
`default_nettype wire
